// ### rtl/adc_cmd_pkg.sv
// Constants, types and state codes of the converter serial command block
// Function
// - Results are 24-bit twos complement, clipped at 7fffff and 800000
// - Reset command byte returns every setting to its default
// - Single-shot start resets filter and begins one fresh conversion
// - Continuous start begins back-to-back conversions; repeat restarts them
// - Sleep command powers down analog, switch and excitation, keeps registers
// - Sleep during a conversion waits for that conversion to finish
// - Start while asleep restores the analog sections
// - Read-data command loads the shifter with the latest result
// - A result finishing mid-read is held until select rises; ready falls afterwards
// - Register read shifts out four bytes from the start address; the decoder waits count-plus-one bytes
// - Register write takes count-plus-one bytes into consecutive registers
// - Register write data commits on the last falling serial edge
// - Address and count fields are two bits; don't-care bits ignored
// - New result drives ready low, and serial output when selected
// - Result buffer readable after ready falls without any command
// - Data shifts out on rising edges, MSB first, three bytes
// - Serial interface works in mode 1 only
// - Input bits are captured on falling serial edges
// - Select high resets the interface and floats the output
// - Ready returns high on the next rising serial edge
package adc_cmd_pkg;
  localparam int         RESULT_W   = 24;
  localparam int         CFG_N      = 4;
  localparam logic [23:0] POS_FS    = 24'h7fffff;
  localparam logic [23:0] NEG_FS    = 24'h800000;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [6:0] CMD_RESET  = 7'h03;
  localparam logic [6:0] CMD_START  = 7'h04;
  localparam logic [6:0] CMD_SLEEP  = 7'h01;
  localparam logic [3:0] CMD_RDATA  = 4'h1;
  localparam logic [3:0] CMD_REGISTER_READ_COMMAND   = 4'h2;
  localparam logic [3:0] CMD_REGISTER_WRITE_COMMAND   = 4'h4;
  localparam logic [2:0] BYTE_LAST  = 3'h7;
  localparam logic [1:0] DATA_LEFT  = 2'h2;
  localparam logic [1:0] CM_REG     = 2'h1;
  localparam int         CM_BIT     = 2;
  localparam logic [1:0] RDYSEL_REG = 2'h3;
  localparam int         RDYSEL_BIT = 1;
  localparam logic [7:0] IDLE_FILL  = 8'hff;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_CONV = 2'b01,
    S_DOWN = 2'b10
  } sys_st_t;

  typedef enum logic [1:0] {
    R_CMD  = 2'b00,
    R_WAIT = 2'b01,
    R_WR   = 2'b10
  } rx_st_t;
endpackage

// ### rtl/adc_cmd_interp.sv
// Serial command interpreter and result readout of the converter
`timescale 1ns/1ps
module adc_cmd_interp
  import adc_cmd_pkg::*;
#(
  parameter int RAW_W = 28
)(
  // System clock and reset
  input  logic             sys_clk,
  input  logic             nrst,
  // Serial link
  input  logic             sclk,
  input  logic             cs_n,
  input  logic             din,
  output logic             sout,
  output logic             sout_oe,
  output logic             result_ready_n,
  // Converter core
  input  logic             conv_done,
  input  logic [RAW_W-1:0] conv_raw,
  output logic             conv_run,
  output logic             filter_reset,
  // Power control
  output logic             analog_on,
  output logic             low_switch_on,
  output logic             excitation_on
);

  typedef struct packed {
    sys_st_t               st;
    logic                  sleep_pend;
    logic                  analog;
    logic                  frst;
    logic [RESULT_W-1:0]   pend;
    logic                  pend_v;
    logic [RESULT_W-1:0]   rbuf;
    logic                  rdy_n;
    logic [1:0]            cs_s;
    logic [1:0]            cm_s;
    logic [2:0]            ts_s;
    logic [2:0]            tp_s;
    logic [2:0]            tr_s;
    logic [2:0]            rs_s;
  } sys_t;

  typedef struct packed {
    rx_st_t                st;
    logic [2:0]            bit_c;
    logic [6:0]            sh;
    logic [1:0]            left;
    logic [1:0]            addr;
    logic [CFG_N-1:0][7:0] stg;
    logic [CFG_N-1:0]      stg_m;
    logic                  load_tog;
    logic                  src_reg;
  } rx_t;

  typedef struct packed {
    logic [CFG_N-1:0][7:0] cfg;
    logic                  t_start;
    logic                  t_sleep;
    logic                  t_reset;
  } cf_t;

  typedef struct packed {
    logic [31:0]           sh;
    logic                  first;
    logic                  seen;
  } tx_t;

  sys_t sy_r, sy_nxt;
  rx_t  rx_r, rx_nxt;
  cf_t  cf_r, cf_nxt;
  tx_t  tx_r, tx_nxt;
  logic rise_tog_r;
  logic link_rst_n;
  logic [7:0] rx_byte;
  logic start_ev, sleep_ev, reset_ev, rise_ev, buf_load;

  function automatic logic [RESULT_W-1:0] clip24(input logic [RAW_W-1:0] v);
    logic hi_ones;
    logic hi_zero;
    hi_ones = &v[RAW_W-2:RESULT_W-1];
    hi_zero = ~|v[RAW_W-2:RESULT_W-1];
    if (!v[RAW_W-1] && !hi_zero)
      return POS_FS;
    else if (v[RAW_W-1] && !hi_ones)
      return NEG_FS;
    else
      return v[RESULT_W-1:0];
  endfunction

  function automatic logic [31:0] reg_word(input logic [CFG_N-1:0][7:0] c,
                                           input logic [1:0] a);
    return {c[a], c[a + 2'd1], c[a + 2'd2], c[a + 2'd3]};
  endfunction

  // Select high holds the link logic in reset
  assign link_rst_n = nrst & ~cs_n;
  assign rx_byte    = {rx_r.sh, din};

  // System domain events
  assign start_ev = sy_r.ts_s[2] ^ sy_r.ts_s[1];
  assign sleep_ev = sy_r.tp_s[2] ^ sy_r.tp_s[1];
  assign reset_ev = sy_r.tr_s[2] ^ sy_r.tr_s[1];
  assign rise_ev  = sy_r.rs_s[2] ^ sy_r.rs_s[1];
  assign buf_load = sy_r.pend_v && sy_r.cs_s[1];

  always_comb
  begin
    sy_nxt      = sy_r;
    sy_nxt.cs_s = {sy_r.cs_s[0], cs_n};
    sy_nxt.cm_s = {sy_r.cm_s[0], cf_r.cfg[CM_REG][CM_BIT]};
    sy_nxt.ts_s = {sy_r.ts_s[1:0], cf_r.t_start};
    sy_nxt.tp_s = {sy_r.tp_s[1:0], cf_r.t_sleep};
    sy_nxt.tr_s = {sy_r.tr_s[1:0], cf_r.t_reset};
    sy_nxt.rs_s = {sy_r.rs_s[1:0], rise_tog_r};
    sy_nxt.frst = 1'b0;
    // Buffer only changes outside a frame, so a read is never torn
    if (rise_ev)
      sy_nxt.rdy_n = 1'b1;
    // Load before capture, so a result ending in the same cycle stays pending
    if (buf_load)
    begin
      sy_nxt.rbuf   = sy_r.pend;
      sy_nxt.pend_v = 1'b0;
      sy_nxt.rdy_n  = 1'b0;
    end
    if (reset_ev)
    begin
      sy_nxt.st         = S_IDLE;
      sy_nxt.sleep_pend = 1'b0;
      sy_nxt.analog     = 1'b1;
      sy_nxt.frst       = 1'b1;
    end
    else
    begin
      if (conv_done && sy_r.st == S_CONV)
      begin
        sy_nxt.pend   = clip24(conv_raw);
        sy_nxt.pend_v = 1'b1;
        if (sy_r.sleep_pend)
        begin
          sy_nxt.st         = S_DOWN;
          sy_nxt.analog     = 1'b0;
          sy_nxt.sleep_pend = 1'b0;
        end
        else if (!sy_r.cm_s[1])
          sy_nxt.st = S_IDLE;
      end
      if (sleep_ev)
      begin
        if (sy_nxt.st == S_CONV)
          sy_nxt.sleep_pend = 1'b1;
        else
        begin
          sy_nxt.st     = S_DOWN;
          sy_nxt.analog = 1'b0;
        end
      end
      if (start_ev)
      begin
        sy_nxt.st         = S_CONV;
        sy_nxt.analog     = 1'b1;
        sy_nxt.frst       = 1'b1;
        sy_nxt.sleep_pend = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sy_r        <= '0;
      sy_r.st     <= S_IDLE;
      sy_r.analog <= 1'b1;
      sy_r.rdy_n  <= 1'b1;
      sy_r.cs_s   <= 2'h3;
    end
    else
      sy_r <= sy_nxt;
  end

  // Falling edge: capture and decode
  always_comb
  begin
    rx_nxt       = rx_r;
    cf_nxt       = cf_r;
    rx_nxt.bit_c = rx_r.bit_c + 3'h1;
    rx_nxt.sh    = rx_byte[6:0];
    if (rx_r.bit_c == BYTE_LAST)
    begin
      case (rx_r.st)
        R_CMD:
        begin
          if (rx_byte[7:1] == CMD_RESET)
          begin
            for (int i = 0; i < CFG_N; i++)
              cf_nxt.cfg[i] = CFG_RST;
            cf_nxt.t_reset = ~cf_r.t_reset;
          end
          else if (rx_byte[7:1] == CMD_START)
            cf_nxt.t_start = ~cf_r.t_start;
          else if (rx_byte[7:1] == CMD_SLEEP)
            cf_nxt.t_sleep = ~cf_r.t_sleep;
          else if (rx_byte[7:4] == CMD_RDATA)
          begin
            rx_nxt.st       = R_WAIT;
            rx_nxt.left     = DATA_LEFT;
            rx_nxt.src_reg  = 1'b0;
            rx_nxt.load_tog = ~rx_r.load_tog;
          end
          else if (rx_byte[7:4] == CMD_REGISTER_READ_COMMAND)
          begin
            rx_nxt.st       = R_WAIT;
            rx_nxt.addr     = rx_byte[3:2];
            rx_nxt.left     = rx_byte[1:0];
            rx_nxt.src_reg  = 1'b1;
            rx_nxt.load_tog = ~rx_r.load_tog;
          end
          else if (rx_byte[7:4] == CMD_REGISTER_WRITE_COMMAND)
          begin
            rx_nxt.st    = R_WR;
            rx_nxt.addr  = rx_byte[3:2];
            rx_nxt.left  = rx_byte[1:0];
            rx_nxt.stg_m = '0;
          end
          // Anything else falls through unchanged
        end
        R_WAIT:
        begin
          if (rx_r.left == 2'h0)
            rx_nxt.st = R_CMD;
          else
            rx_nxt.left = rx_r.left - 2'h1;
        end
        R_WR:
        begin
          rx_nxt.stg[rx_r.addr]   = rx_byte;
          rx_nxt.stg_m[rx_r.addr] = 1'b1;
          rx_nxt.addr             = rx_r.addr + 2'h1;
          if (rx_r.left == 2'h0)
          begin
            rx_nxt.st = R_CMD;
            for (int i = 0; i < CFG_N; i++)
              if (rx_nxt.stg_m[i])
                cf_nxt.cfg[i] = rx_nxt.stg[i];
          end
          else
            rx_nxt.left = rx_r.left - 2'h1;
        end
        default:
          rx_nxt.st = R_CMD;
      endcase
    end
  end

  always_ff @(negedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rx_r    <= '0;
      rx_r.st <= R_CMD;
    end
    else
      rx_r <= rx_nxt;
  end

  always_ff @(negedge sclk or negedge nrst)
  begin
    if (!nrst)
      cf_r <= '0;
    else
      cf_r <= cf_nxt;
  end

  // Rising edge: shift out, MSB first
  always_comb
  begin
    tx_nxt = tx_r;
    if (tx_r.first)
    begin
      tx_nxt.sh    = {sy_r.rbuf, IDLE_FILL};
      tx_nxt.first = 1'b0;
    end
    else if (rx_r.load_tog != tx_r.seen)
    begin
      tx_nxt.seen = rx_r.load_tog;
      if (rx_r.src_reg)
        tx_nxt.sh = reg_word(cf_r.cfg, rx_r.addr);
      else
        tx_nxt.sh = {sy_r.rbuf, IDLE_FILL};
    end
    else
      tx_nxt.sh = {tx_r.sh[30:0], 1'b1};
  end

  always_ff @(posedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      tx_r       <= '0;
      tx_r.sh    <= '1;
      tx_r.first <= 1'b1;
    end
    else
      tx_r <= tx_nxt;
  end

  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
      rise_tog_r <= 1'b0;
    else
      rise_tog_r <= ~rise_tog_r;
  end

  // Pins and core controls
  assign sout_oe        = ~cs_n;
  assign sout           = tx_r.first ?
                          (cf_r.cfg[RDYSEL_REG][RDYSEL_BIT] ? sy_r.rdy_n : 1'b1) :
                          tx_r.sh[31];
  assign result_ready_n = sy_r.rdy_n;
  assign conv_run       = (sy_r.st == S_CONV);
  assign filter_reset   = sy_r.frst;
  assign analog_on      = sy_r.analog;
  assign low_switch_on  = sy_r.analog;
  assign excitation_on  = sy_r.analog;

  sequence conv_end_s;
    conv_done && sy_r.st == S_CONV && !reset_ev && !start_ev && !sleep_ev;
  endsequence

  sequence wake_s;
    start_ev && !reset_ev && !sy_r.analog;
  endsequence

  clip_pos_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (conv_end_s and (!conv_raw[RAW_W-1] && |conv_raw[RAW_W-2:RESULT_W-1]))
      |=> sy_r.pend == POS_FS && sy_r.pend_v)
    else $error("positive overrange not clipped");

  clip_neg_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (conv_end_s and (conv_raw[RAW_W-1] && !(&conv_raw[RAW_W-2:RESULT_W-1])))
      |=> sy_r.pend == NEG_FS)
    else $error("negative overrange not clipped");

  start_filt_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start_ev && !reset_ev) |=> filter_reset && conv_run ##1 !filter_reset)
    else $error("start did not reset filter and run");

  cont_run_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (conv_end_s and (sy_r.cm_s[1] && !sy_r.sleep_pend)) |=> conv_run)
    else $error("continuous conversions stopped");

  single_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (conv_end_s and !sy_r.cm_s[1]) |=> !conv_run)
    else $error("single conversion kept running");

  sleep_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sleep_ev && sy_r.st == S_CONV && !reset_ev && !start_ev && !conv_done)
      |=> analog_on && sy_r.sleep_pend)
    else $error("sleep cut a running conversion");

  sleep_done_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (conv_end_s and sy_r.sleep_pend) |=> !analog_on && !low_switch_on && !conv_run)
    else $error("sleep not entered after conversion");

  wake_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wake_s |=> analog_on && excitation_on)
    else $error("start did not wake analog");

  ready_fall_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    buf_load |=> !result_ready_n && sy_r.rbuf == $past(sy_r.pend))
    else $error("ready not lowered on new result");

  ready_rise_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rise_ev && !buf_load) |=> result_ready_n)
    else $error("ready not raised after serial edge");

  reset_cfg_a: assert property (@(negedge sclk) disable iff (!link_rst_n)
    (rx_r.st == R_CMD && rx_r.bit_c == BYTE_LAST && rx_byte[7:1] == CMD_RESET)
      |=> cf_r.cfg == '0)
    else $error("reset command left settings");

endmodule

// ### dv/spi_host_model.sv
// Behavioural host that masters the serial link in mode 1
`timescale 1ns/1ps
module spi_host_model (
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input  logic sout,
  input  logic sout_oe
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // Open a frame, leaving setup time before the first rise
  task automatic sel();
  begin
    cs_n = 1'b0;
    #50;
  end
  endtask

  // Clock idles low; bit changes on the rise, both sides take on the fall
  // Released output line reads as pulled up
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    int i;
  begin
    rx = '0;
    for (i = n - 1; i >= 0; i--)
    begin
      #7.5 sclk = 1'b1;
      din = tx[i];
      #7.5 sclk = 1'b0;
      rx = {rx[62:0], sout_oe ? sout : 1'b1};
    end
  end
  endtask

  // Close a frame; released data line shows no stale value
  task automatic desel();
  begin
    #20 cs_n = 1'b1;
    din = ~din;
  end
  endtask
endmodule

// ### dv/tb_adc_cmd_interp.sv
// Self-checking bench of the serial command interpreter
`timescale 1ns/1ps
module tb_adc_cmd_interp;
  import adc_cmd_pkg::*;
  localparam int RW = 28;
  typedef struct packed {logic [RW-1:0] raw; logic [7:0] start; logic [23:0] res;} row_t;
  logic          sys_clk, nrst, sclk, cs_n, din, sout, sout_oe, result_ready_n;
  logic          conv_done, conv_run, filter_reset, analog_on, low_switch_on, excitation_on;
  logic [RW-1:0] conv_raw;
  logic [63:0]   rx;
  int            n_fail, checks_done, fr_cnt, k;
  row_t          rows [5] = '{{28'h0000123, 8'h08, 24'h000123},
                              {28'hfffffff, 8'h09, 24'hffffff},
                              {28'h0800000, 8'h08, 24'h7fffff},
                              {28'hf7fffff, 8'h09, 24'h800000},
                              {28'hf800000, 8'h08, 24'h800000}};

  adc_cmd_interp #(.RAW_W(RW)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .din(din), .sout(sout), .sout_oe(sout_oe),
    .result_ready_n(result_ready_n), .conv_done(conv_done), .conv_raw(conv_raw),
    .conv_run(conv_run), .filter_reset(filter_reset), .analog_on(analog_on),
    .low_switch_on(low_switch_on), .excitation_on(excitation_on));
  spi_host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .sout(sout), .sout_oe(sout_oe));

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (filter_reset === 1'b1) fr_cnt++;

  task automatic chk_w(input logic [63:0] got, input logic [63:0] exp);
  begin
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic chk_b(input logic got, input logic exp);
  begin
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic frame(input logic [63:0] tx, input int n);
  begin
    host_u.sel();
    host_u.xfer(tx, n, rx);
    host_u.desel();
    cyc(6);
  end
  endtask

  // Finish a conversion and wait for the ready pin
  task automatic conv(input logic [RW-1:0] raw);
    int i;
  begin
    conv_done = 1'b1;
    conv_raw  = raw;
    cyc(1);
    conv_done = 1'b0;
    for (i = 0; i < 40 && result_ready_n !== 1'b0; i++) cyc(1);
    chk_b(result_ready_n, 1'b0);
  end
  endtask

  task automatic test_done();
  begin
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  initial
  begin
    #500us;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  initial
  begin
    nrst      = 1'b0;
    conv_done = 1'b0;
    conv_raw  = '0;
    cyc(8);
    chk_b(result_ready_n, 1'b1);
    chk_b(analog_on, 1'b1);
    nrst = 1'b1;
    cyc(4);
    for (k = 0; k < 5; k++)
    begin
      frame({56'h0, rows[k].start}, 8);
      chk_b(conv_run, 1'b1);
      conv(rows[k].raw);
      frame(64'h0, 24);
      chk_w(rx[23:0], rows[k].res);
      chk_b(result_ready_n, 1'b1);
      $display("row %0d done", k);
    end
    frame(64'h43a5003c02, 40);
    frame(64'h2300000000, 40);
    chk_w(rx[31:0], 32'ha5003c02);
    frame(64'h2d0000, 24);
    chk_w(rx[15:0], 16'h02a5);
    $display("register test done");
    frame(64'h08, 8);
    conv(28'h0012345);
    host_u.sel();
    chk_b(sout, 1'b0);
    host_u.xfer(64'h0, 24, rx);
    host_u.desel();
    cyc(6);
    chk_w(rx[23:0], 24'h012345);
    chk_b(sout_oe, 1'b0);
    frame(64'h1f000000, 32);
    chk_w(rx[23:0], 24'h012345);
    $display("readout test done");
    frame(64'h08, 8);
    k = fr_cnt;
    frame(64'h09, 8);
    chk_w(fr_cnt - k, 64'h1);
    frame(64'h03, 8);
    chk_b(analog_on, 1'b1);
    conv(28'h0000042);
    cyc(4);
    chk_b(analog_on | low_switch_on | excitation_on, 1'b0);
    frame(64'h2300000000, 40);
    chk_w(rx[31:0], 32'ha5003c02);
    frame(64'h08, 8);
    chk_b(analog_on & conv_run, 1'b1);
    conv(28'h0);
    frame(64'hff, 8);
    chk_b(conv_run, 1'b0);
    frame(64'h2300000000, 40);
    chk_w(rx[31:0], 32'ha5003c02);
    $display("power test done");
    frame(64'h4404, 16);
    frame(64'h08, 8);
    conv(28'h0);
    cyc(10);
    chk_b(conv_run, 1'b1);
    fork
      frame(64'h10000000, 32);
      begin
        cyc(8);
        conv_raw  = 28'h0000077;
        conv_done = 1'b1;
        cyc(1);
        conv_done = 1'b0;
      end
    join
    chk_w(rx[23:0], 24'h000000);
    chk_b(result_ready_n, 1'b0);
    frame(64'h0, 24);
    chk_w(rx[23:0], 24'h000077);
    frame(64'h07, 8);
    cyc(5032);
    chk_b(conv_run, 1'b0);
    frame(64'h2300000000, 40);
    chk_w(rx[31:0], 32'h0);
    $display("reset test done");
    test_done();
  end
endmodule
